// File: ivm_pkg.sv
/*
  Shared constants of the interrupt vector map: widths, vector numbers,
  spacing and the reset vector address.
  Assumes program addresses are word addresses, 16 bits wide.
*/
package ivm_pkg;

  localparam int unsigned VEC_NUM_W = 5;
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned NUM_SRC   = 28;

  localparam logic [VEC_NUM_W-1:0] VEC_RESET       = 5'h01;
  localparam logic [VEC_NUM_W-1:0] VEC_FIRST_IRQ   = 5'h02;
  localparam logic [VEC_NUM_W-1:0] VEC_EXT_LINE_0  = 5'h02;
  localparam logic [VEC_NUM_W-1:0] VEC_PIN_GROUP_0 = 5'h0A;
  localparam logic [VEC_NUM_W-1:0] VEC_USB_GENERAL = 5'h0C;
  localparam logic [VEC_NUM_W-1:0] VEC_USB_ENDPNT  = 5'h0D;
  localparam logic [VEC_NUM_W-1:0] VEC_WATCHDOG    = 5'h0E;
  localparam logic [VEC_NUM_W-1:0] VEC_T16_CAPTURE = 5'h0F;
  localparam logic [VEC_NUM_W-1:0] VEC_T16_MATCH_A = 5'h10;
  localparam logic [VEC_NUM_W-1:0] VEC_T16_OVERFLW = 5'h13;
  localparam logic [VEC_NUM_W-1:0] VEC_T8_MATCH_A  = 5'h14;
  localparam logic [VEC_NUM_W-1:0] VEC_T8_OVERFLW  = 5'h16;
  localparam logic [VEC_NUM_W-1:0] VEC_SPI_DONE    = 5'h17;
  localparam logic [VEC_NUM_W-1:0] VEC_SER1_RX     = 5'h18;
  localparam logic [VEC_NUM_W-1:0] VEC_SER1_TXE    = 5'h19;
  localparam logic [VEC_NUM_W-1:0] VEC_SER1_TXC    = 5'h1A;
  localparam logic [VEC_NUM_W-1:0] VEC_ANALOG_CMP  = 5'h1B;
  localparam logic [VEC_NUM_W-1:0] VEC_DATA_NVM    = 5'h1C;
  localparam logic [VEC_NUM_W-1:0] VEC_PROG_STORE  = 5'h1D;

  // Words between consecutive vectors, same for every memory size
  localparam logic [ADDR_W-1:0] VEC_SPACING = 16'h0002;
  localparam logic [ADDR_W-1:0] RESET_ADDR  = 16'h0000;

  // Reset values of the state
  localparam logic                 RST_VALID    = 1'b1;
  localparam logic                 RST_RESET_PD = 1'b0;
  localparam logic [VEC_NUM_W-1:0] RST_NUM      = 5'h01;
  localparam logic [ADDR_W-1:0]    RST_ADDR     = 16'h0000;

endpackage

// File: ivm_prio_enc.sv
/*
  Lowest-index-wins priority encoder over the request vector.
  Assumes purely combinational use inside the vector map.
*/
`timescale 1ns/1ps
module ivm_prio_enc
  import ivm_pkg::*;
(
  // Requests
  input  wire logic [NUM_SRC-1:0]   i_req,
  // Result
  output logic                      o_found,
  output logic [VEC_NUM_W-1:0]      o_index
);

  always_comb begin
    o_found = 1'b0;
    o_index = '0;
    // Walk downward so the lowest set bit is the last to write
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_found = 1'b1;
        o_index = VEC_NUM_W'(i);
      end
    end
  end

endmodule // ivm_prio_enc

// File: ivm_vector_map.sv
/*
  Interrupt vector map: turns reset causes and interrupt requests into a
  vector number and program word address offered to the core.
  Assumes request inputs are synchronous levels held until the core
  services them, and that the core clears the source after taking it.
*/
// Function
// - Every reset cause leads to vector 1 at address 0000.
// - External lines 0 to 7 use vectors 2 to 9, addresses 0002-0010.
// - Pin-change groups 0 and 1 use vectors 10 and 11 at 0012, 0014.
// - USB general request uses vector 12 at address 0016.
// - USB endpoint request uses vector 13 at address 0018.
// - Timer16 capture, matches A-C and overflow at 001C through 0024.
// - Timer8 match A, match B, overflow at 0026, 0028, 002A.
// - SPI transfer complete uses vector 23 at address 002C.
// - Serial1 receive, buffer empty, transmit complete at 002E, 0030, 0032.
// - Comparator, data memory ready, program store ready at 0034-0038.
// - Consecutive vectors lie two program words apart.
// - With base select set, boot section start is added to interrupt vectors, not to the reset vector.
`timescale 1ns/1ps
module ivm_vector_map
  import ivm_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_sys_rst,
  // Reset causes and relocation
  input  wire logic                 i_reset_cause,
  input  wire logic                 i_vector_base_select,
  input  wire logic [ADDR_W-1:0]    i_boot_start,
  // Interrupt sources
  input  wire logic [7:0]           i_ext_irq_line,
  input  wire logic [1:0]           i_pin_change_group,
  input  wire logic                 i_usb_general,
  input  wire logic                 i_usb_endpoint,
  input  wire logic                 i_watchdog_timeout_source,
  input  wire logic                 i_timer16_capture_event,
  input  wire logic [2:0]           i_timer16_match,
  input  wire logic                 i_timer16_overflow,
  input  wire logic [1:0]           i_timer8_match,
  input  wire logic                 i_timer8_overflow,
  input  wire logic                 i_spi_transfer_complete,
  input  wire logic                 i_serial1_receive_complete,
  input  wire logic                 i_serial1_tx_buffer_empty,
  input  wire logic                 i_serial1_transmit_complete,
  input  wire logic                 i_analog_comparator,
  input  wire logic                 i_data_nvm_ready,
  input  wire logic                 i_program_store_ready,
  // Core handshake
  input  wire logic                 i_vec_ack,
  output logic                      o_vec_valid,
  output logic [VEC_NUM_W-1:0]      o_vec_num,
  output logic [ADDR_W-1:0]         o_vec_addr
);

  typedef struct packed {
    logic                 valid;
    logic                 reset_pd;
    logic [VEC_NUM_W-1:0] num;
    logic [ADDR_W-1:0]    addr;
  } ivm_state_t;

  ivm_state_t           state;
  ivm_state_t           next_state;
  logic [NUM_SRC-1:0]   req;
  logic                 req_found;
  logic [VEC_NUM_W-1:0] req_index;
  logic [VEC_NUM_W-1:0] win_num;

  function automatic logic [VEC_NUM_W-1:0] slot(input logic [VEC_NUM_W-1:0] vec);
    slot = vec - VEC_FIRST_IRQ;
  endfunction

  function automatic logic [ADDR_W-1:0] vec_addr(input logic [VEC_NUM_W-1:0] vec,
                                                 input logic              sel,
                                                 input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] offs;
    offs = ADDR_W'(vec - VEC_RESET) * VEC_SPACING;
    vec_addr = sel ? ADDR_W'(base + offs) : offs;
  endfunction

  // Request vector, bit k stands for vector k plus the first request vector
  always_comb begin
    req = '0;
    req[slot(VEC_EXT_LINE_0) +: 8]  = i_ext_irq_line;
    req[slot(VEC_PIN_GROUP_0) +: 2] = i_pin_change_group;
    req[slot(VEC_USB_GENERAL)]      = i_usb_general;
    req[slot(VEC_USB_ENDPNT)]       = i_usb_endpoint;
    req[slot(VEC_WATCHDOG)]         = i_watchdog_timeout_source;
    req[slot(VEC_T16_CAPTURE)]      = i_timer16_capture_event;
    req[slot(VEC_T16_MATCH_A) +: 3] = i_timer16_match;
    req[slot(VEC_T16_OVERFLW)]      = i_timer16_overflow;
    req[slot(VEC_T8_MATCH_A) +: 2]  = i_timer8_match;
    req[slot(VEC_T8_OVERFLW)]       = i_timer8_overflow;
    req[slot(VEC_SPI_DONE)]         = i_spi_transfer_complete;
    req[slot(VEC_SER1_RX)]          = i_serial1_receive_complete;
    req[slot(VEC_SER1_TXE)]         = i_serial1_tx_buffer_empty;
    req[slot(VEC_SER1_TXC)]         = i_serial1_transmit_complete;
    req[slot(VEC_ANALOG_CMP)]       = i_analog_comparator;
    req[slot(VEC_DATA_NVM)]         = i_data_nvm_ready;
    req[slot(VEC_PROG_STORE)]       = i_program_store_ready;
  end

  ivm_prio_enc u_prio (
    .i_req   (req),
    .o_found (req_found),
    .o_index (req_index)
  );

  assign win_num = VEC_NUM_W'(req_index + VEC_FIRST_IRQ);

  always_comb begin
    next_state = state;
    // A reset cause arriving while a vector is held is kept, not lost
    if (i_reset_cause) begin
      next_state.reset_pd = 1'b1;
    end
    if (!state.valid || i_vec_ack) begin
      next_state.valid = 1'b0;
      if (i_reset_cause || state.reset_pd) begin
        // Reset vector never moves with the base select
        next_state.valid    = 1'b1;
        next_state.reset_pd = 1'b0;
        next_state.num      = VEC_RESET;
        next_state.addr     = RESET_ADDR;
      end else if (req_found) begin
        next_state.valid = 1'b1;
        next_state.num   = win_num;
        next_state.addr  = vec_addr(win_num, i_vector_base_select, i_boot_start);
      end
    end
  end

  // Reset presents the reset vector straight away
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= '{valid: RST_VALID, reset_pd: RST_RESET_PD, num: RST_NUM, addr: RST_ADDR};
    end else begin
      state <= next_state;
    end
  end

  assign o_vec_valid = state.valid;
  assign o_vec_num   = state.num;
  assign o_vec_addr  = state.addr;

endmodule // ivm_vector_map

// File: ivm_vector_map_chk.sv
/* Assertions on the vector map top ports.
   Assumes one clock; checks are off while reset is high. */
`timescale 1ns/1ps
module ivm_vector_map_chk
  import ivm_pkg::*;
(
  // Watched ports
  input wire logic                 i_ref_clk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_reset_cause,
  input wire logic                 i_vector_base_select,
  input wire logic [7:0]           i_ext_irq_line,
  input wire logic                 i_vec_ack,
  input wire logic                 o_vec_valid,
  input wire logic [VEC_NUM_W-1:0] o_vec_num,
  input wire logic [ADDR_W-1:0]    o_vec_addr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rst_addr; o_vec_valid && o_vec_num == 5'h01 |-> o_vec_addr == 16'h0000; endproperty
  a_rst_addr: assert property (p_rst_addr) else $error("reset address");
  property p_start; $fell(i_sys_rst) |-> o_vec_valid && o_vec_num == 5'h01; endproperty
  a_start: assert property (p_start) else $error("no reset vector");
  property p_rst_win; (!o_vec_valid || i_vec_ack) && i_reset_cause |=> o_vec_num == 5'h01;
  endproperty
  a_rst_win: assert property (p_rst_win) else $error("reset lost");
  property p_addr; ((!o_vec_valid || i_vec_ack) && !i_vector_base_select) ##1
    (o_vec_valid && o_vec_num != 5'h01) |-> o_vec_addr == {10'h000, o_vec_num - 5'h01, 1'b0};
  endproperty
  a_addr: assert property (p_addr) else $error("address");
  property p_answer; (!o_vec_valid || i_vec_ack) && |i_ext_irq_line |=> o_vec_valid; endproperty
  a_answer: assert property (p_answer) else $error("no offer");
  property p_prio; (!o_vec_valid || i_vec_ack) && i_ext_irq_line[0] |=>
    o_vec_num inside {5'h01, 5'h02}; endproperty
  a_prio: assert property (p_prio) else $error("priority");
  property p_hold; o_vec_valid && !i_vec_ack |=> o_vec_valid && $stable({o_vec_num, o_vec_addr});
  endproperty
  a_hold: assert property (p_hold) else $error("offer changed");
  property p_range; o_vec_valid |-> o_vec_num inside {[5'h01:5'h1D]}; endproperty
  a_range: assert property (p_range) else $error("number range");
endmodule // ivm_vector_map_chk
bind ivm_vector_map ivm_vector_map_chk u_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_reset_cause(i_reset_cause), .i_vector_base_select(i_vector_base_select),
  .i_ext_irq_line(i_ext_irq_line), .i_vec_ack(i_vec_ack), .o_vec_valid(o_vec_valid),
  .o_vec_num(o_vec_num), .o_vec_addr(o_vec_addr));

// File: ivm_core_model.sv
/* Core model: raises ack 1 to 4 cycles after each vector is offered.
   Assumes the map's clock and reset. */
`timescale 1ns/1ps
module ivm_core_model (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  // Handshake
  input  wire logic i_vec_valid,
  output logic      o_vec_ack
);
  logic [1:0] dly;
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_vec_ack <= 1'b0;
      dly       <= 2'h0;
    end else begin
      o_vec_ack <= i_vec_valid && !o_vec_ack && dly == 2'h0;
      if (o_vec_ack) dly <= 2'($urandom);
      else if (i_vec_valid && dly != 2'h0) dly <= dly - 2'h1;
    end
  end
endmodule // ivm_core_model

// File: ivm_vector_map_tb.sv
/* Bench of the vector map: single, paired and reset-cause requests.
   Assumes requests are pulses given while nothing is offered, save the last reset cause. */
`timescale 1ns/1ps
module ivm_vector_map_tb;
  logic        clk, rst, rc, sel, ack, vld;
  logic [27:0] req;
  logic [15:0] boot, addr;
  logic [4:0]  num;
  logic [20:0] q[$];
  int          n_fail, total_checks, cyc;
  ivm_vector_map dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_reset_cause(rc),
    .i_vector_base_select(sel), .i_boot_start(boot), .i_ext_irq_line(req[7:0]),
    .i_pin_change_group(req[9:8]), .i_usb_general(req[10]), .i_usb_endpoint(req[11]),
    .i_watchdog_timeout_source(req[12]), .i_timer16_capture_event(req[13]),
    .i_timer16_match(req[16:14]), .i_timer16_overflow(req[17]), .i_timer8_match(req[19:18]),
    .i_timer8_overflow(req[20]), .i_spi_transfer_complete(req[21]),
    .i_serial1_receive_complete(req[22]), .i_serial1_tx_buffer_empty(req[23]),
    .i_serial1_transmit_complete(req[24]), .i_analog_comparator(req[25]),
    .i_data_nvm_ready(req[26]), .i_program_store_ready(req[27]), .i_vec_ack(ack),
    .o_vec_valid(vld), .o_vec_num(num), .o_vec_addr(addr));
  ivm_core_model core (.i_ref_clk(clk), .i_sys_rst(rst), .i_vec_valid(vld), .o_vec_ack(ack));
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [27:0] r, input logic c);
    logic [4:0] n;
    n = 5'h01;
    do begin @(posedge clk); #1; end while (vld !== 1'b0);
    for (int i = 27; i >= 0; i--)
      if (!c && r[i]) n = 5'(i + 2);
    sel = 1'($urandom);
    boot = 16'($urandom);
    req = r;
    rc = c;
    q.push_back({n, n == 5'h01 ? 16'h0000 : {10'h000, n - 5'h01, 1'b0} + (sel ? boot : 16'h0000)});
    @(posedge clk);
    #1 req = '0;
    rc = 1'b0;
  endtask
  task summarize;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (vld === 1'b1 && ack === 1'b1) chk({num, addr}, q.size() ? q.pop_front() : 'x);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin n_fail++; summarize(); end
  end
  initial begin
    rst = 1'b1; rc = 1'b0; sel = 1'b0; req = '0; boot = '0;
    void'($urandom(69356));
    q.push_back({5'h01, 16'h0000});
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    for (int k = 0; k < 28; k++) send(28'h1 << k, 1'b0);
    send(28'h8000001, 1'b0);
    repeat (12) send(28'h1 << ($urandom % 28) | 28'h1 << ($urandom % 28), 1'b0);
    send(28'($urandom), 1'b1);
    // Reset cause while a vector is still held must wait, then win
    send(28'h4, 1'b0);
    #1 rc = 1'b1;
    q.push_back({5'h01, 16'h0000});
    @(posedge clk);
    #1 rc = 1'b0;
    for (int i = 0; i < 50 && q.size() != 0; i++) @(posedge clk);
    // Any vector still owed means the map hung
    if (q.size() != 0) n_fail++;
    summarize();
  end
endmodule // ivm_vector_map_tb
